// ---- lps_timer.sv ----
`timescale 1ns/1ns
// ==========================================================================
// shared constants for the line-out power and clock sequencer
// ==========================================================================
package lps_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;                       // system clock period
    localparam int NS_PER_MS = 1000000;                      // nanoseconds in one millisecond
    localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;   // clock cycles per millisecond
    localparam logic [15:0] SETTLE_TIME_MS = 16'h012c;       // 300 ms output rise or fall
    localparam logic [15:0] LOCK_TIME_MS = 16'h00a0;         // 160 ms loop lock, frame clock reference
    localparam logic [7:0] UNITY_IN_VOL = 8'h91;             // input volume code for 0 dB

    // apb register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // command register bit positions
    localparam int CMD_LINE_UP = 0;
    localparam int CMD_LINE_DOWN = 1;
    localparam int CMD_CLK_STOP = 2;
    localparam int CMD_CLK_START = 3;
    localparam int CMD_STANDBY = 4;
    localparam int CMD_W = 5;

    // configuration register fields
    localparam int CFG_MODE_LSB = 0;       // [2:0] clock mode
    localparam int CFG_REC_L = 3;          // left recording channel powered
    localparam int CFG_REC_R = 4;          // right recording channel powered
    localparam int CFG_RATE_CHG = 5;       // sample rate changed since last lock
    localparam int CFG_PDN_REL = 6;        // release the power-down pin
    localparam int CFG_OUT_VOL_LSB = 8;    // [15:8] out_vol_left
    localparam int CFG_IN_VOL_LSB = 16;    // [23:16] input volume while recording

    // status register bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_LINE_UP = 1;
    localparam int STAT_CLK_RUN = 2;
    localparam int STAT_STANDBY = 3;
    localparam int STAT_REFUSED = 4;       // sticky, write one to clear

    // clock modes
    localparam logic [2:0] MODE_LOOP_MASTER = 3'h0;
    localparam logic [2:0] MODE_LOOP_SLAVE_BF = 3'h1;
    localparam logic [2:0] MODE_LOOP_SLAVE_MCLK = 3'h2;
    localparam logic [2:0] MODE_EXT_SLAVE = 3'h3;
    localparam logic [2:0] MODE_EXT_MASTER = 3'h4;

    // device control field codes on the device write port
    localparam logic [3:0] F_PATH = 4'h0;        // dac_to_line_path_en
    localparam logic [3:0] F_IN_VOL_L = 4'h1;    // in_vol_left
    localparam logic [3:0] F_IN_VOL_R = 4'h2;    // in_vol_right
    localparam logic [3:0] F_OUT_VOL_L = 4'h3;   // out_vol_left
    localparam logic [3:0] F_LINE_PS = 4'h4;     // line_power_save
    localparam logic [3:0] F_PLAY_PWR = 4'h5;    // {line_amp, mixer_amp, playback_conv} power
    localparam logic [3:0] F_LOOP_PWR = 4'h6;    // loop_power
    localparam logic [3:0] F_MCLK_OUT = 4'h7;    // master_clk_out_en
    localparam logic [3:0] F_COMMON_PWR = 4'h8;  // common_volt_power

    typedef enum logic [2:0] {SEQ_UP, SEQ_DOWN, SEQ_STOP, SEQ_START, SEQ_STBY} lps_seq_t;
    typedef enum logic [2:0] {OP_SKIP, OP_WR, OP_WAIT_SETTLE, OP_WAIT_LOCK, OP_CLK_OFF, OP_CLK_ON,
                              OP_END} lps_op_t;
    typedef enum {ST_IDLE, ST_FETCH, ST_WRITE, ST_WAIT} lps_state_t;
endpackage

// ==========================================================================
// millisecond wait timer
// ==========================================================================
module lps_timer
    import lps_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,          // one-cycle pulse, loads ms_i
    input wire logic [15:0] ms_i,      // wait length in milliseconds
    output logic done_o                // one-cycle pulse when the wait ends
);
    logic [31:0] div_reg;              // millisecond divider
    logic [15:0] left_reg;             // milliseconds still to wait
    logic run_reg;                     // wait in progress
    wire ms_tick = run_reg && (div_reg == 32'(CYC_MS - 1));  // enable pulse once per ms
    wire last_ms = ms_tick && (left_reg <= 16'h0001);

    // divider restarts with each wait so every millisecond is whole
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 32'h0000_0000;
        end else if (start_i || ms_tick) begin
            div_reg <= 32'h0000_0000;
        end else if (run_reg) begin
            div_reg <= div_reg + 32'h0000_0001;
        end
    end

    // countdown; a zero length still waits one millisecond
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_reg <= 16'h0000;
            run_reg <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= last_ms;
            if (start_i) begin
                left_reg <= ms_i;
                run_reg <= 1'b1;
            end else if (last_ms) begin
                run_reg <= 1'b0;
            end else if (ms_tick) begin
                left_reg <= left_reg - 16'h0001;
            end
        end
    end
endmodule

// ---- lps_ctrl.sv ----
`timescale 1ns/1ns
module lps_ctrl
    import lps_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS,                 // clock cycles per millisecond
    parameter logic [15:0] SETTLE_MS = SETTLE_TIME_MS, // line output settle wait
    parameter logic [15:0] LOCK_MS = LOCK_TIME_MS      // loop lock wait
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic DEV_REQ_O,
    output logic [3:0] DEV_FIELD_O,
    output logic [7:0] DEV_VAL_O,
    input wire logic DEV_ACK_I,
    output logic MCLK_RUN_O,
    output logic FRAME_CLKS_RUN_O,
    output logic POWER_DOWN_PIN_N_O,
    output logic BUSY_O
);
    // ======================================================================
    // reset release
    // ======================================================================
    logic rst_meta_reg;    // first stage, read only by the second
    logic rst_n;           // released reset used everywhere

    // async assert, clocked release through two flops
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ======================================================================
    // apb slave, one wait state so every answer comes from a flop
    // ======================================================================
    logic [31:0] cfg_reg;                // configuration
    logic [CMD_W-1:0] cmd_reg;           // command pulses, one cycle
    logic refused_reg;                   // sticky refusal flag
    logic line_up_reg;                   // line output running
    logic clk_run_reg;                   // clocks supplied
    logic standby_reg;                   // standby reached
    logic busy_reg;                      // a sequence is running
    logic set_refused;                   // refusal event from the sequencer

    wire apb_access = PSEL_I && PENABLE_I;
    wire apb_done = apb_access && PREADY_O;           // transfer completes at this edge
    wire hit_cmd = (PADDR_I == OFS_CMD);
    wire hit_cfg = (PADDR_I == OFS_CFG);
    wire hit_stat = (PADDR_I == OFS_STAT);
    wire hit_any = hit_cmd || hit_cfg || hit_stat;
    wire wr_done = apb_done && PWRITE_I && hit_any;
    wire [31:0] stat_word = {27'h0, refused_reg, standby_reg, clk_run_reg, line_up_reg, busy_reg};
    wire [31:0] rd_word = hit_cfg ? cfg_reg : (hit_stat ? stat_word : 32'h0000_0000);
    wire clr_refused = wr_done && hit_stat && PWDATA_I[STAT_REFUSED];

    // ready rises one cycle into the access phase and falls after it
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= apb_access && !PREADY_O;
            PSLVERR_O <= apb_access && !PREADY_O && !hit_any;
            PRDATA_O <= (apb_access && !PREADY_O && !PWRITE_I) ? rd_word : 32'h0000_0000;
        end
    end

    // register writes take effect at the completing edge only
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= CFG_RESET;
            cmd_reg <= '0;
        end else begin
            cmd_reg <= (wr_done && hit_cmd) ? PWDATA_I[CMD_W-1:0] : '0;
            if (wr_done && hit_cfg) begin
                cfg_reg <= PWDATA_I;
            end
        end
    end

    // a refusal in the clearing cycle still lands
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            refused_reg <= 1'b0;
        end else if (set_refused) begin
            refused_reg <= 1'b1;
        end else if (clr_refused) begin
            refused_reg <= 1'b0;
        end
    end

    // ======================================================================
    // configuration decode
    // ======================================================================
    wire [2:0] mode = cfg_reg[CFG_MODE_LSB +: 3];
    wire rec_on = cfg_reg[CFG_REC_L] || cfg_reg[CFG_REC_R];
    wire loop_mode = (mode == MODE_LOOP_MASTER) || (mode == MODE_LOOP_SLAVE_BF) ||
                     (mode == MODE_LOOP_SLAVE_MCLK);
    wire mclk_out_mode = (mode == MODE_LOOP_MASTER) || (mode == MODE_LOOP_SLAVE_MCLK);
    wire [7:0] out_vol = cfg_reg[CFG_OUT_VOL_LSB +: 8];
    // with recording off the input volume must sit at unity
    wire [7:0] in_vol = rec_on ? cfg_reg[CFG_IN_VOL_LSB +: 8] : UNITY_IN_VOL;
    wire need_lock = loop_mode && cfg_reg[CFG_RATE_CHG];

    // ======================================================================
    // step table: one operation per sequence index
    // ======================================================================
    lps_seq_t seq_reg;         // running sequence
    logic [3:0] idx_reg;       // step index within it
    lps_op_t op;               // decoded operation
    logic [3:0] fld;           // device field of a write
    logic [7:0] val;           // value of a write
    wire stby_skip_down = (seq_reg == SEQ_STBY) && !line_up_reg;
    lps_op_t down_wr;      // line-down write, skipped by standby when already down
    assign down_wr = stby_skip_down ? OP_SKIP : OP_WR;

    always_comb begin
        op = OP_END;
        fld = F_PATH;
        val = 8'h00;
        case (seq_reg)
            SEQ_UP: begin
                // the volume link default lets out_vol_left cover both channels
                case (idx_reg)
                    4'd0: begin op = OP_WR; fld = F_PATH; val = 8'h01; end
                    4'd1: begin op = OP_WR; fld = F_IN_VOL_L; val = in_vol; end
                    4'd2: begin op = OP_WR; fld = F_IN_VOL_R; val = in_vol; end
                    4'd3: begin op = OP_WR; fld = F_OUT_VOL_L; val = out_vol; end
                    4'd4: begin op = OP_WR; fld = F_LINE_PS; val = 8'h01; end
                    4'd5: begin op = need_lock ? OP_WAIT_LOCK : OP_SKIP; end
                    4'd6: begin op = OP_WR; fld = F_PLAY_PWR; val = 8'h07; end
                    4'd7: begin op = OP_WAIT_SETTLE; end
                    4'd8: begin op = OP_WR; fld = F_LINE_PS; val = 8'h00; end
                    default: begin op = OP_END; end
                endcase
            end
            SEQ_DOWN, SEQ_STBY: begin
                // standby first brings the line output down if it is up
                case (idx_reg)
                    4'd0: begin op = down_wr; fld = F_LINE_PS; val = 8'h01; end
                    4'd1: begin op = down_wr; fld = F_PLAY_PWR; end
                    4'd2: begin op = down_wr; fld = F_PATH; end
                    4'd3: begin op = stby_skip_down ? OP_SKIP : OP_WAIT_SETTLE; end
                    4'd4: begin op = down_wr; fld = F_LINE_PS; end
                    4'd5: begin op = (seq_reg == SEQ_STBY && loop_mode) ? OP_WR : OP_SKIP; fld = F_LOOP_PWR; end
                    4'd6: begin op = (seq_reg == SEQ_STBY && mclk_out_mode) ? OP_WR : OP_SKIP; fld = F_MCLK_OUT; end
                    4'd7: begin op = (seq_reg == SEQ_STBY) ? OP_CLK_OFF : OP_SKIP; end
                    4'd8: begin op = (seq_reg == SEQ_STBY) ? OP_WR : OP_SKIP; fld = F_COMMON_PWR; end
                    default: begin op = OP_END; end
                endcase
            end
            SEQ_STOP: begin
                // external modes stop at once; the device parks its own clock outputs
                case (idx_reg)
                    4'd0: begin op = loop_mode ? OP_WR : OP_SKIP; fld = F_LOOP_PWR; end
                    4'd1: begin op = mclk_out_mode ? OP_WR : OP_SKIP; fld = F_MCLK_OUT; end
                    4'd2: begin op = OP_CLK_OFF; end
                    default: begin op = OP_END; end
                endcase
            end
            SEQ_START: begin
                case (idx_reg)
                    4'd0: begin op = OP_WR; fld = F_COMMON_PWR; val = 8'h01; end
                    4'd1: begin op = OP_CLK_ON; end
                    4'd2: begin op = mclk_out_mode ? OP_WR : OP_SKIP; fld = F_MCLK_OUT; val = 8'h01; end
                    4'd3: begin op = loop_mode ? OP_WR : OP_SKIP; fld = F_LOOP_PWR; val = 8'h01; end
                    4'd4: begin op = loop_mode ? OP_WAIT_LOCK : OP_SKIP; end
                    default: begin op = OP_END; end
                endcase
            end
            default: begin op = OP_END; end
        endcase
    end

    // ======================================================================
    // command acceptance
    // ======================================================================
    lps_state_t state_reg;
    lps_state_t state_next;
    wire idle = (state_reg == ST_IDLE);
    wire any_cmd = |cmd_reg;
    // stopping clocks while a converter is in use is refused
    wire stop_bad = rec_on || line_up_reg;
    wire bad_cmd = (cmd_reg[CMD_LINE_UP] && (!clk_run_reg || line_up_reg)) ||
                   (cmd_reg[CMD_CLK_STOP] && stop_bad) ||
                   (cmd_reg[CMD_STANDBY] && rec_on);
    wire accept = idle && any_cmd && !bad_cmd;
    assign set_refused = any_cmd && (!idle || bad_cmd);
    lps_seq_t seq_pick;
    assign seq_pick = cmd_reg[CMD_LINE_UP] ? SEQ_UP : cmd_reg[CMD_LINE_DOWN] ? SEQ_DOWN :
                      cmd_reg[CMD_CLK_STOP] ? SEQ_STOP : cmd_reg[CMD_CLK_START] ? SEQ_START : SEQ_STBY;

    // ======================================================================
    // sequencer
    // ======================================================================
    logic tmr_start_reg;      // starts the millisecond timer
    logic [15:0] tmr_ms_reg;  // its length
    logic tmr_done;           // wait finished
    wire step_on = (state_reg == ST_FETCH && op != OP_WR && op != OP_WAIT_SETTLE &&
                    op != OP_WAIT_LOCK && op != OP_END) ||
                   (state_reg == ST_WRITE && DEV_ACK_I) || (state_reg == ST_WAIT && tmr_done);
    wire seq_end = (state_reg == ST_FETCH) && (op == OP_END);

    lps_timer #(
        .CYC_MS(CYC_MS)
    ) u_timer (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .start_i(tmr_start_reg),
        .ms_i(tmr_ms_reg),
        .done_o(tmr_done)
    );

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = accept ? ST_FETCH : ST_IDLE;
            ST_FETCH: begin
                if (op == OP_WR) begin
                    state_next = ST_WRITE;
                end else if (op == OP_WAIT_SETTLE || op == OP_WAIT_LOCK) begin
                    state_next = ST_WAIT;
                end else if (op == OP_END) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WRITE: state_next = DEV_ACK_I ? ST_FETCH : ST_WRITE;  // held until the device takes it
            ST_WAIT: state_next = tmr_done ? ST_FETCH : ST_WAIT;
            default: state_next = ST_IDLE;
        endcase
    end

    // state, sequence and step index
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            seq_reg <= SEQ_UP;
            idx_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                seq_reg <= seq_pick;
                idx_reg <= 4'h0;
            end else if (step_on) begin
                idx_reg <= idx_reg + 4'h1;
            end
        end
    end

    // device write port, request stands until acknowledged
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            DEV_REQ_O <= 1'b0;
            DEV_FIELD_O <= 4'h0;
            DEV_VAL_O <= 8'h00;
        end else if (state_reg == ST_FETCH && op == OP_WR) begin
            DEV_REQ_O <= 1'b1;
            DEV_FIELD_O <= fld;
            DEV_VAL_O <= val;
        end else if (state_reg == ST_WRITE && DEV_ACK_I) begin
            DEV_REQ_O <= 1'b0;
        end
    end

    // timer launch; settle covers both rise to common voltage and fall to ground
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            tmr_start_reg <= 1'b0;
            tmr_ms_reg <= 16'h0000;
        end else begin
            tmr_start_reg <= (state_reg == ST_FETCH) && (op == OP_WAIT_SETTLE || op == OP_WAIT_LOCK);
            tmr_ms_reg <= (op == OP_WAIT_LOCK) ? LOCK_MS : SETTLE_MS;
        end
    end

    // clock supply; the stop comes only after the register steps above it
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            clk_run_reg <= 1'b0;
            MCLK_RUN_O <= 1'b0;
            FRAME_CLKS_RUN_O <= 1'b0;
        end else if (state_reg == ST_FETCH && (op == OP_CLK_OFF || op == OP_CLK_ON)) begin
            clk_run_reg <= (op == OP_CLK_ON);
            MCLK_RUN_O <= (op == OP_CLK_ON);
            FRAME_CLKS_RUN_O <= (op == OP_CLK_ON) && (mode != MODE_EXT_MASTER);
        end
    end

    // status flags updated as a sequence finishes
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            line_up_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else if (seq_end) begin
            line_up_reg <= (seq_reg == SEQ_UP);
            standby_reg <= (seq_reg == SEQ_STBY);
        end else if (!POWER_DOWN_PIN_N_O) begin
            // the device forgets everything while its pin is low
            line_up_reg <= 1'b0;
        end
    end

    // busy and power-down pin, low from reset until software releases it
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            BUSY_O <= 1'b0;
            POWER_DOWN_PIN_N_O <= 1'b0;
        end else begin
            busy_reg <= (state_next != ST_IDLE);
            BUSY_O <= (state_next != ST_IDLE);
            POWER_DOWN_PIN_N_O <= cfg_reg[CFG_PDN_REL];
        end
    end
endmodule

// ---- lps_dev_model.sv ----
`timescale 1ns/1ns
// ==========
// codec side: keeps field writes, acks after lat cycles
module lps_dev_model
    import lps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pdn_n_i,
    input wire logic req_i,
    input wire logic [3:0] field_i,
    input wire logic [7:0] val_i,
    output logic ack_o
);
    logic [7:0] regs [0:8]; // codec control fields
    int lat = 1; // ack delay, the bench slows it
    int cnt = 0;
    localparam int INIT_FRAMES = 1059; // playback init cycle length
    logic rec_on = 1'b0; // recording power, never set by the bench so it stays low
    logic conv_q = 1'b0; // converter power bit one cycle ago
    int init_left = 0; // init frames left; one cycle stands for a frame here
    wire line_normal = regs[F_PLAY_PWR][2] && !regs[F_LINE_PS][0];
    // input samples forced to zero, level control held at the input volume
    wire zero_play = (init_left != 0);
    always @(posedge clk_i) begin
        ack_o <= rst_n_i && req_i && !ack_o && cnt >= lat;
        cnt <= (req_i && !ack_o) ? cnt + 1 : 0;
        conv_q <= regs[F_PLAY_PWR][0];
        // each rise restarts the cycle; recording skips it
        if (regs[F_PLAY_PWR][0] && !conv_q) init_left <= rec_on ? 0 : INIT_FRAMES;
        else if (init_left != 0) init_left <= init_left - 1;
        if (!pdn_n_i) regs <= '{default: 8'h00};
        else if (req_i && ack_o) regs[field_i] <= val_i;
    end
endmodule

// ---- lps_ctrl_properties.sv ----
`timescale 1ns/1ns
// ==========
// port checks of the sequencer
module lps_ctrl_properties
    import lps_pkg::*;
#(parameter int CYC_MS = 10, parameter logic [15:0] SETTLE_MS = 16'h0002) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic DEV_REQ_O,
    input wire logic [3:0] DEV_FIELD_O,
    input wire logic [7:0] DEV_VAL_O,
    input wire logic DEV_ACK_I,
    input wire logic MCLK_RUN_O
);
    localparam int SETTLE_CYC = int'(SETTLE_MS) * CYC_MS;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    wire take = DEV_REQ_O && DEV_ACK_I; // a field write lands
    wire zero_wr = DEV_REQ_O && DEV_VAL_O == 8'h00; // a field being cleared
    logic ps_reg;
    logic [7:0] pwr_reg;
    int cnt_reg; // cycles since last power write
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ps_reg <= 1'b0;
            pwr_reg <= 8'h00;
            cnt_reg <= 0;
        end else begin
            if (take && DEV_FIELD_O == F_LINE_PS) ps_reg <= DEV_VAL_O[0];
            if (take && DEV_FIELD_O == F_PLAY_PWR) pwr_reg <= DEV_VAL_O;
            cnt_reg <= (take && DEV_FIELD_O == F_PLAY_PWR) ? 0 : cnt_reg + 1;
        end
    end
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
    a_req_hold: assert property (DEV_REQ_O && !DEV_ACK_I |=> DEV_REQ_O && $stable({DEV_FIELD_O, DEV_VAL_O}))
        else $error("request dropped");
    a_req_gap: assert property (take |=> !DEV_REQ_O) else $error("no idle gap");
    a_ps_first: assert property (DEV_REQ_O && DEV_FIELD_O == F_PLAY_PWR |-> ps_reg)
        else $error("power without power-save");
    a_ps_wait: assert property (zero_wr && DEV_FIELD_O == F_LINE_PS |-> cnt_reg >= SETTLE_CYC - 1)
        else $error("power-save cleared early");
    a_path_late: assert property (zero_wr && DEV_FIELD_O == F_PATH |-> pwr_reg == 8'h00)
        else $error("path off while powered");
    a_clk_idle: assert property ($fell(MCLK_RUN_O) |-> pwr_reg == 8'h00) else $error("clock stop in use");
    a_common_last: assert property (zero_wr && DEV_FIELD_O == F_COMMON_PWR |-> !MCLK_RUN_O)
        else $error("common off with clock");
    cover property (take && DEV_FIELD_O == F_PLAY_PWR && DEV_VAL_O == 8'h07);
    cover property (PSLVERR_O);
    cover property ($fell(MCLK_RUN_O));
endmodule
bind lps_ctrl lps_ctrl_properties #(.CYC_MS(CYC_MS), .SETTLE_MS(SETTLE_MS)) u_chk (.*);

// ---- tb_lps_ctrl.sv ----
`timescale 1ns/1ns
// ==========
// apb command sequences, codec fields checked
module tb_lps_ctrl
    import lps_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er, rdy, serr, req, ack, mclk, pdn_n, busy;
    logic fck;
    logic [7:0] paddr = 8'h00, val;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] fld;
    int err_total = 0, num_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    lps_ctrl #(.CYC_MS(10), .SETTLE_MS(16'h0002), .LOCK_MS(16'h0001)) DUT (.CLK_SYS_I(clk), .RSTN_I(rstn),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(rdy), .PSLVERR_O(serr), .DEV_REQ_O(req), .DEV_FIELD_O(fld), .DEV_VAL_O(val), .DEV_ACK_I(ack),
        .MCLK_RUN_O(mclk), .FRAME_CLKS_RUN_O(fck), .POWER_DOWN_PIN_N_O(pdn_n), .BUSY_O(busy));
    lps_dev_model dev (.clk_i(clk), .rst_n_i(rstn), .pdn_n_i(pdn_n), .req_i(req), .field_i(fld), .val_i(val),
        .ack_o(ack));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prdata;
        er = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic dchk(input logic [3:0] f, input logic [7:0] e);
        chk({24'h0, dev.regs[f]}, {24'h0, e});
    endtask
    // command, then wait for the sequence to finish
    task automatic run(input logic [31:0] c);
        apb(1'b1, OFS_CMD, c);
        repeat (3) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(OFS_CFG, CFG_RESET);
        rdc(8'h0c, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, OFS_CFG, 32'h0000_4040);
        run(32'h1);
        rdc(OFS_STAT, 32'h10);
        chk({31'h0, pdn_n}, 32'h1);
        apb(1'b1, OFS_STAT, 32'h10);
        $display("test registers done");
        run(32'h8);
        dchk(F_MCLK_OUT, 8'h01);
        chk({31'h0, fck}, 32'h1);
        dev.lat = 6;
        run(32'h1);
        rdc(OFS_STAT, 32'h6);
        chk({31'h0, dev.zero_play}, 32'h1);
        chk({31'h0, dev.line_normal}, 32'h1);
        dchk(F_IN_VOL_R, UNITY_IN_VOL);
        dchk(F_OUT_VOL_L, 8'h40);
        dchk(F_PLAY_PWR, 8'h07);
        dchk(F_LINE_PS, 8'h00);
        run(32'h4);
        rdc(OFS_STAT, 32'h16);
        $display("test line up done");
        dev.lat = 0;
        run(32'h2);
        dchk(F_PATH, 8'h00);
        chk({31'h0, dev.line_normal}, 32'h0);
        run(32'h4);
        chk({31'h0, mclk}, 32'h0);
        chk({31'h0, fck}, 32'h0);
        dchk(F_LOOP_PWR, 8'h00);
        run(32'h8);
        run(32'h10);
        rdc(OFS_STAT, 32'h18);
        dchk(F_COMMON_PWR, 8'h00);
        $display("test clocks done");
        apb(1'b1, OFS_CFG, 32'h0000_4044);
        run(32'h8);
        chk({31'h0, mclk}, 32'h1);
        chk({31'h0, fck}, 32'h0);
        apb(1'b1, OFS_CFG, 32'h0000_404c);
        run(32'h4);
        chk({31'h0, mclk}, 32'h1);
        rdc(OFS_STAT, 32'h14);
        $display("test ext master done");
        tally_and_finish();
    end
endmodule
